// *** verilog/pmi_pkg.sv ***
// Constants for the push motion and input function block
package pmi_pkg;
	// Register byte offsets
	localparam logic [7:0] PMI_REG_CTRL = 8'h00;
	localparam logic [7:0] PMI_REG_PUSH_CFG = 8'h04;
	localparam logic [7:0] PMI_REG_TARGET = 8'h08;
	localparam logic [7:0] PMI_REG_INPUT_CFG = 8'h0C;
	localparam logic [7:0] PMI_REG_JOG_CFG = 8'h10;
	localparam logic [7:0] PMI_REG_MISC_CFG = 8'h14;
	localparam logic [7:0] PMI_REG_STATUS = 8'h18;
	localparam logic [7:0] PMI_REG_PUSH_TIME = 8'h1C;
	// Command bits of the control register
	localparam int PMI_CMD_PUSH_ABS = 0;
	localparam int PMI_CMD_PUSH_REL = 1;
	localparam int PMI_CMD_PAUSE = 2;
	localparam int PMI_CMD_RESTART = 3;
	localparam int PMI_CMD_STOP = 4;
	localparam int PMI_CMD_WARN_CLR = 5;
	// Field positions
	localparam int PMI_F_TORQUE = 8;
	localparam int PMI_F_HOLD = 16;
	localparam int PMI_F_FILTER = 16;
	localparam int PMI_F_INCH_DIST = 16;
	localparam int PMI_F_UNIT = 16;
	localparam int PMI_F_REPORT = 24;
	localparam int PMI_F_WARN = 16;
	localparam int PMI_F_INPUTS = 24;
	localparam int PMI_F_SERVO = 28;
	localparam int PMI_F_MANUAL = 29;
	// Reset values
	localparam logic [31:0] PMI_PUSH_CFG_RST = 32'h0000_0000;
	localparam logic [31:0] PMI_INPUT_CFG_RST = 32'h0001_0000;
	localparam logic [31:0] PMI_JOG_CFG_RST = 32'h0001_0001;
	localparam logic [31:0] PMI_MISC_CFG_RST = 32'h0000_0000;
	// Input function codes
	localparam logic [2:0] PMI_FN_GENERAL = 3'h0;
	localparam logic [2:0] PMI_FN_ORIGIN = 3'h1;
	localparam logic [2:0] PMI_FN_LIM_CCW = 3'h2;
	localparam logic [2:0] PMI_FN_LIM_CW = 3'h3;
	localparam logic [2:0] PMI_FN_MANUAL = 3'h4;
	localparam logic [2:0] PMI_FN_SERVO = 3'h5;
	localparam logic [2:0] PMI_FN_JOG_CCW = 3'h6;
	localparam logic [2:0] PMI_FN_JOG_CW = 3'h7;
	// Status word values
	localparam logic [15:0] PMI_ST_INPOS = 16'h0008;
	localparam logic [15:0] PMI_ST_SERVO_OFF = 16'h0010;
	localparam logic [15:0] PMI_ST_PUSH = 16'h0020;
	localparam logic [15:0] PMI_ST_PUSH_DONE = 16'h0028;
	localparam logic [15:0] PMI_ST_OP_WARN = 16'h0100;
	localparam logic [15:0] PMI_ST_PUSH_MISS = 16'h0128;
	// Warning bits
	localparam int PMI_WARN_PUSH = 0;
	localparam int PMI_WARN_LIMIT = 2;
	// Timing
	localparam int PMI_CLK_HZ = 20000000;
	localparam int PMI_TICK_MS = 1;
	localparam int PMI_MS_CYCLES = PMI_CLK_HZ / 1000 * PMI_TICK_MS;
	localparam logic [31:0] PMI_PPS_STEP = 32'h0000_0064;
	typedef enum logic [1:0] {PMI_PS_IDLE, PMI_PS_MOVE, PMI_PS_PUSH, PMI_PS_PAUSE} pmi_push_t;
	typedef enum logic [1:0] {PMI_JS_IDLE, PMI_JS_INCH, PMI_JS_JOG} pmi_jog_t;
endpackage : pmi_pkg

// *** verilog/pmi_push_inputs.sv ***
// Push move control, input functions and AHB-Lite register slave
//
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ns
module pmi_push_inputs
	import pmi_pkg::*;
#(
	parameter int MS_CYCLES = PMI_MS_CYCLES
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	input wire logic [3:0] in_pins,
	input wire logic [31:0] pos_now,
	input wire logic torque_reached,
	input wire logic target_reached,
	output logic [31:0] push_target,
	output logic [7:0] torque_cap_pct,
	output logic cap_cw,
	output logic cap_ccw,
	output logic move_run,
	output logic decel_stop,
	output logic inch_start,
	output logic [6:0] inch_dist,
	output logic jog_run,
	output logic jog_dir_cw,
	output logic [31:0] jog_speed_pps,
	output logic servo_enable,
	output logic alarm_clear,
	output logic report_req
);
	logic [31:0] push_cfg_q, target_q, input_cfg_q, jog_cfg_q, misc_cfg_q, req_tgt;
	logic [31:0] hrdata_q, push_ms_q, push_tgt_q, jog_speed_q;
	logic [15:0] status_q, tick_cnt_q;
	logic [7:0] warn_q, wr_addr_q;
	logic wr_q, servo_q, alarm_clr_q, decel_q, inch_q, report_q, dir_cw_q, was_push_q, tick, timed_done, quiet;
	logic [3:0] sync1_q, sync2_q, filt_q, filt_prev_q, rise, fall;
	logic [2:0] func [4];
	logic [3:0] fn_lim_ccw, fn_lim_cw, fn_manual, fn_servo, fn_jog_ccw, fn_jog_cw;
	logic manual, lim_ccw_on, lim_cw_on, lim_evt, srv_rise, srv_fall;
	logic cmd_abs, cmd_rel, cmd_pause, cmd_restart, cmd_stop, cmd_warn_clr, start_ok, tgt_cw;
	logic [1:0] mode;
	logic [5:0] filter_ms;
	logic [11:0] shift_ms, js_ms_q;
	pmi_push_t ps_q;
	pmi_jog_t js_q;
	logic js_dir_q, jog_ccw_on, jog_cw_on, jog_rise_any, jog_held;
	// AHB-Lite slave: zero wait states, always OKAY
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_q;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_q <= 1'b0;
			wr_addr_q <= 8'h00;
			hrdata_q <= 32'h0000_0000;
		end else begin
			wr_q <= hsel && hready && htrans[1] && hwrite;
			wr_addr_q <= haddr[7:0];
			if (hsel && hready && htrans[1] && !hwrite) begin
				case (haddr[7:0])
					PMI_REG_PUSH_CFG: hrdata_q <= push_cfg_q;
					PMI_REG_TARGET: hrdata_q <= target_q;
					PMI_REG_INPUT_CFG: hrdata_q <= input_cfg_q;
					PMI_REG_JOG_CFG: hrdata_q <= jog_cfg_q;
					PMI_REG_MISC_CFG: hrdata_q <= misc_cfg_q;
					PMI_REG_STATUS: hrdata_q <= {2'h0, manual, servo_q, filt_q, warn_q, status_q};
					PMI_REG_PUSH_TIME: hrdata_q <= push_ms_q;
					default: hrdata_q <= 32'h0000_0000;
				endcase
			end
		end
	end
	// Configuration registers
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			push_cfg_q <= PMI_PUSH_CFG_RST;
			target_q <= 32'h0000_0000;
			input_cfg_q <= PMI_INPUT_CFG_RST;
			jog_cfg_q <= PMI_JOG_CFG_RST;
			misc_cfg_q <= PMI_MISC_CFG_RST;
		end else if (wr_q) begin
			case (wr_addr_q)
				PMI_REG_PUSH_CFG: push_cfg_q <= hwdata;
				PMI_REG_TARGET: target_q <= hwdata;
				PMI_REG_INPUT_CFG: input_cfg_q <= hwdata;
				PMI_REG_JOG_CFG: jog_cfg_q <= hwdata;
				PMI_REG_MISC_CFG: misc_cfg_q <= hwdata;
				default: ;
			endcase
		end
	end
	// Command strobes and field extraction
	assign cmd_abs = wr_q && wr_addr_q == PMI_REG_CTRL && hwdata[PMI_CMD_PUSH_ABS];
	assign cmd_rel = wr_q && wr_addr_q == PMI_REG_CTRL && hwdata[PMI_CMD_PUSH_REL];
	assign cmd_pause = wr_q && wr_addr_q == PMI_REG_CTRL && hwdata[PMI_CMD_PAUSE];
	assign cmd_restart = wr_q && wr_addr_q == PMI_REG_CTRL && hwdata[PMI_CMD_RESTART];
	assign cmd_stop = wr_q && wr_addr_q == PMI_REG_CTRL && hwdata[PMI_CMD_STOP];
	assign cmd_warn_clr = wr_q && wr_addr_q == PMI_REG_CTRL && hwdata[PMI_CMD_WARN_CLR];
	assign mode = push_cfg_q[1:0];
	assign filter_ms = input_cfg_q[PMI_F_FILTER +: 6];
	assign shift_ms = misc_cfg_q[11:0];
	// Millisecond tick divider
	assign tick = tick_cnt_q == 16'(MS_CYCLES - 1);
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			tick_cnt_q <= 16'h0000;
		else
			tick_cnt_q <= tick ? 16'h0000 : tick_cnt_q + 16'h0001;
	end
	// Synchronise and filter each input, then decode its function
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_in
			logic [5:0] fcnt_q;
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sync1_q[gi] <= 1'b0;
					sync2_q[gi] <= 1'b0;
					filt_q[gi] <= 1'b0;
					filt_prev_q[gi] <= 1'b0;
					fcnt_q <= 6'h00;
				end else begin
					sync1_q[gi] <= in_pins[gi];
					sync2_q[gi] <= sync1_q[gi];
					filt_prev_q[gi] <= filt_q[gi];
					if (sync2_q[gi] == filt_q[gi])
						fcnt_q <= 6'h00;
					else if (tick) begin
						if (fcnt_q + 6'h01 >= filter_ms) begin
							filt_q[gi] <= sync2_q[gi];
							fcnt_q <= 6'h00;
						end else
							fcnt_q <= fcnt_q + 6'h01;
					end
				end
			end
			assign func[gi] = input_cfg_q[4 * gi +: 3];
			assign fn_lim_ccw[gi] = func[gi] == PMI_FN_LIM_CCW && gi < 2;
			assign fn_lim_cw[gi] = func[gi] == PMI_FN_LIM_CW && gi < 2;
			assign fn_manual[gi] = func[gi] == PMI_FN_MANUAL;
			assign fn_servo[gi] = func[gi] == PMI_FN_SERVO;
			assign fn_jog_ccw[gi] = func[gi] == PMI_FN_JOG_CCW && gi >= 2;
			assign fn_jog_cw[gi] = func[gi] == PMI_FN_JOG_CW && gi >= 2;
		end
	endgenerate
	assign rise = filt_q & ~filt_prev_q;
	assign fall = ~filt_q & filt_prev_q;
	assign manual = |(fn_manual & filt_q);
	assign lim_ccw_on = |(fn_lim_ccw & filt_q);
	assign lim_cw_on = |(fn_lim_cw & filt_q);
	assign lim_evt = |((fn_lim_ccw | fn_lim_cw) & rise);
	assign srv_rise = |(fn_servo & rise);
	assign srv_fall = |(fn_servo & fall);
	assign jog_ccw_on = |(fn_jog_ccw & filt_q);
	assign jog_cw_on = |(fn_jog_cw & filt_q);
	assign jog_rise_any = |((fn_jog_ccw | fn_jog_cw) & rise);
	// Push start: target choice and direction check
	assign req_tgt = cmd_rel ? pos_now + target_q : target_q;
	assign tgt_cw = $signed(req_tgt) > $signed(pos_now);
	assign start_ok = (cmd_abs || cmd_rel) && !manual && ps_q == PMI_PS_IDLE
		&& !(tgt_cw && lim_cw_on) && !(!tgt_cw && lim_ccw_on);
	assign timed_done = ps_q == PMI_PS_PUSH && mode[0] && tick
		&& push_ms_q + 32'h1 >= {16'h0000, push_cfg_q[PMI_F_HOLD +: 16]};
	// Push state machine
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			ps_q <= PMI_PS_IDLE;
			push_tgt_q <= 32'h0000_0000;
			dir_cw_q <= 1'b0;
			was_push_q <= 1'b0;
		end else begin
			case (ps_q)
				PMI_PS_IDLE: if (start_ok) begin
					ps_q <= PMI_PS_MOVE;
					push_tgt_q <= req_tgt;
					dir_cw_q <= tgt_cw;
				end
				PMI_PS_MOVE, PMI_PS_PUSH: begin
					was_push_q <= ps_q == PMI_PS_PUSH;
					if (cmd_stop || lim_evt || timed_done)
						ps_q <= PMI_PS_IDLE;
					else if (cmd_pause)
						ps_q <= PMI_PS_PAUSE;
					else if (ps_q == PMI_PS_MOVE && torque_reached)
						ps_q <= PMI_PS_PUSH;
					else if (ps_q == PMI_PS_MOVE && target_reached)
						ps_q <= PMI_PS_IDLE;
				end
				PMI_PS_PAUSE: begin
					if (cmd_pause || cmd_stop || lim_evt)
						ps_q <= PMI_PS_IDLE;
					else if (cmd_restart)
						ps_q <= was_push_q ? PMI_PS_PUSH : PMI_PS_MOVE;
				end
				default: ps_q <= PMI_PS_IDLE;
			endcase
		end
	end
	// Accumulated push time
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			push_ms_q <= 32'h0000_0000;
		else if (start_ok)
			push_ms_q <= 32'h0000_0000;
		else if (ps_q == PMI_PS_PUSH && tick)
			push_ms_q <= push_ms_q + 32'h1;
	end
	// Torque cap directions
	assign torque_cap_pct = push_cfg_q[PMI_F_TORQUE +: 8];
	assign cap_cw = ps_q != PMI_PS_IDLE && (mode[1] || dir_cw_q);
	assign cap_ccw = ps_q != PMI_PS_IDLE && (mode[1] || !dir_cw_q);
	assign move_run = ps_q == PMI_PS_MOVE || ps_q == PMI_PS_PUSH;
	assign push_target = push_tgt_q;
	// Inching and jog state machine
	assign jog_held = js_dir_q ? jog_cw_on : jog_ccw_on;
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			js_q <= PMI_JS_IDLE;
			js_ms_q <= 12'h000;
			js_dir_q <= 1'b0;
			inch_q <= 1'b0;
		end else begin
			inch_q <= 1'b0;
			case (js_q)
				PMI_JS_IDLE: if (manual && jog_rise_any) begin
					js_dir_q <= jog_cw_on;
					js_ms_q <= 12'h000;
					if (!(jog_cw_on ? lim_cw_on : lim_ccw_on)) begin
						if (shift_ms == 12'h000)
							js_q <= PMI_JS_JOG;
						else begin
							js_q <= PMI_JS_INCH;
							inch_q <= 1'b1;
						end
					end
				end
				PMI_JS_INCH: begin
					if (!jog_held || !manual)
						js_q <= PMI_JS_IDLE;
					else if (tick) begin
						if (js_ms_q + 12'h001 >= shift_ms)
							js_q <= PMI_JS_JOG;
						js_ms_q <= js_ms_q + 12'h001;
					end
				end
				PMI_JS_JOG: if (!jog_held || !manual || lim_evt)
					js_q <= PMI_JS_IDLE;
				default: js_q <= PMI_JS_IDLE;
			endcase
		end
	end
	assign jog_run = js_q == PMI_JS_JOG;
	assign jog_dir_cw = js_dir_q;
	assign inch_start = inch_q;
	assign inch_dist = jog_cfg_q[PMI_F_INCH_DIST +: 7];
	assign jog_speed_pps = jog_speed_q;
	// Speed scaling by the speed unit
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn)
			jog_speed_q <= 32'h0000_0000;
		else if (misc_cfg_q[PMI_F_UNIT +: 4] == 4'h0)
			jog_speed_q <= {17'h00000, jog_cfg_q[14:0]} * PMI_PPS_STEP;
		else
			jog_speed_q <= {17'h00000, jog_cfg_q[14:0]};
	end
	// Servo, alarm clear and limit stop pulses
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			servo_q <= 1'b0;
			alarm_clr_q <= 1'b0;
			decel_q <= 1'b0;
		end else begin
			alarm_clr_q <= srv_rise;
			decel_q <= lim_evt;
			if (srv_rise)
				servo_q <= 1'b1;
			else if (srv_fall)
				servo_q <= 1'b0;
		end
	end
	assign servo_enable = servo_q;
	assign alarm_clear = alarm_clr_q;
	assign decel_stop = decel_q;
	// Status word, warnings and automatic report
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			status_q <= PMI_ST_SERVO_OFF;
			warn_q <= 8'h00;
			report_q <= 1'b0;
		end else begin
			report_q <= 1'b0;
			if (srv_rise) begin
				status_q <= PMI_ST_INPOS;
				report_q <= misc_cfg_q[PMI_F_REPORT];
			end else if (srv_fall)
				status_q <= PMI_ST_SERVO_OFF;
			else if (lim_evt)
				status_q <= PMI_ST_OP_WARN;
			else if (timed_done) begin
				status_q <= PMI_ST_PUSH_DONE;
				report_q <= misc_cfg_q[PMI_F_REPORT];
			end else if (ps_q == PMI_PS_MOVE && !cmd_stop && !cmd_pause && torque_reached)
				status_q <= PMI_ST_PUSH;
			else if (ps_q == PMI_PS_MOVE && !cmd_stop && !cmd_pause && target_reached) begin
				status_q <= PMI_ST_PUSH_MISS;
				report_q <= misc_cfg_q[PMI_F_REPORT];
			end
			// Set wins over a clear in the same cycle
			warn_q[PMI_WARN_PUSH] <= (warn_q[PMI_WARN_PUSH] && !cmd_warn_clr) || (ps_q == PMI_PS_MOVE
				&& !cmd_stop && !cmd_pause && !lim_evt && !torque_reached && target_reached);
			warn_q[PMI_WARN_LIMIT] <= (warn_q[PMI_WARN_LIMIT] && !cmd_warn_clr) || lim_evt;
		end
	end
	assign report_req = report_q;
	// Checks
	assign quiet = !srv_rise && !srv_fall && !lim_evt && !cmd_stop && !cmd_pause;
	property p_cap_both;
		@(posedge hclk) disable iff (!hresetn) (ps_q != PMI_PS_IDLE && mode[1]) |-> (cap_cw && cap_ccw);
	endproperty
	a_cap_both: assert property (p_cap_both) else $error("both-direction cap missing");
	property p_cap_one;
		@(posedge hclk) disable iff (!hresetn) (ps_q != PMI_PS_IDLE && !mode[1]) |-> (cap_cw != cap_ccw);
	endproperty
	a_cap_one: assert property (p_cap_one) else $error("one-direction cap wrong");
	property p_pause_keep;
		@(posedge hclk) disable iff (!hresetn) (ps_q == PMI_PS_PAUSE) ##1 (ps_q == PMI_PS_PAUSE) |-> $stable(push_ms_q);
	endproperty
	a_pause_keep: assert property (p_pause_keep) else $error("hold time moved while paused");
	property p_double_pause;
		@(posedge hclk) disable iff (!hresetn) (ps_q == PMI_PS_PAUSE && cmd_pause) |=> (!cap_cw && !cap_ccw);
	endproperty
	a_double_pause: assert property (p_double_pause) else $error("second pause kept cap");
	property p_timed_done;
		@(posedge hclk) disable iff (!hresetn) (timed_done && quiet) |=> (status_q == PMI_ST_PUSH_DONE && ps_q == PMI_PS_IDLE);
	endproperty
	a_timed_done: assert property (p_timed_done) else $error("timed push did not finish");
	property p_continuous;
		@(posedge hclk) disable iff (!hresetn) (ps_q == PMI_PS_PUSH && !mode[0] && quiet) |=> ps_q == PMI_PS_PUSH;
	endproperty
	a_continuous: assert property (p_continuous) else $error("continuous push ended");
	property p_torque32;
		@(posedge hclk) disable iff (!hresetn) (ps_q == PMI_PS_MOVE && torque_reached && quiet) |=> status_q == PMI_ST_PUSH;
	endproperty
	a_torque32: assert property (p_torque32) else $error("status 32 missing");
	property p_miss;
		@(posedge hclk) disable iff (!hresetn)
			(ps_q == PMI_PS_MOVE && target_reached && !torque_reached && quiet)
			|=> (status_q == PMI_ST_PUSH_MISS && warn_q[PMI_WARN_PUSH]);
	endproperty
	a_miss: assert property (p_miss) else $error("missed-object status wrong");
	property p_servo_on;
		@(posedge hclk) disable iff (!hresetn) srv_rise |=> (servo_enable && alarm_clear && status_q == PMI_ST_INPOS);
	endproperty
	a_servo_on: assert property (p_servo_on) else $error("servo toggle on failed");
	property p_manual_block;
		@(posedge hclk) disable iff (!hresetn) (manual && ps_q == PMI_PS_IDLE) |=> ps_q == PMI_PS_IDLE;
	endproperty
	a_manual_block: assert property (p_manual_block) else $error("motion started in manual mode");
	property p_jog_now;
		@(posedge hclk) disable iff (!hresetn)
			(js_q == PMI_JS_IDLE && manual && jog_rise_any && shift_ms == 12'h000 && !lim_ccw_on && !lim_cw_on)
			|=> (jog_run && !inch_start);
	endproperty
	a_jog_now: assert property (p_jog_now) else $error("zero shift time did not jog");
	c_push_done: cover property (@(posedge hclk) disable iff (!hresetn) timed_done);
	c_resume: cover property (@(posedge hclk) disable iff (!hresetn) ps_q == PMI_PS_PAUSE && cmd_restart);
	c_jog: cover property (@(posedge hclk) disable iff (!hresetn) js_q == PMI_JS_INCH ##1 js_q == PMI_JS_JOG);
endmodule : pmi_push_inputs

// *** test/pmi_motor_model.sv ***
// Behavioural motor drive answering the push move outputs
`timescale 1ns/1ns
module pmi_motor_model #(
	parameter logic [31:0] HOME = 32'h0000_0010
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic move_run,
	input wire logic obj,
	output logic [31:0] pos_now,
	output logic torque_reached,
	output logic target_reached
);
	logic [1:0] cnt_q;
	// Position stays at home; the shaft is not modelled
	assign pos_now = HOME;
	// After a short travel, meet the object or reach the target
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cnt_q <= 2'h0;
			torque_reached <= 1'b0;
			target_reached <= 1'b0;
		end else if (!move_run) begin
			cnt_q <= 2'h0;
			torque_reached <= 1'b0;
			target_reached <= 1'b0;
		end else if (cnt_q != 2'h3) begin
			cnt_q <= cnt_q + 2'h1;
		end else begin
			torque_reached <= obj;
			target_reached <= !obj;
		end
	end
endmodule : pmi_motor_model

// *** test/pmi_push_inputs_tb.sv ***
// Self-checking bench for the push motion and input block
`timescale 1ns/1ns
module pmi_push_inputs_tb;
	import pmi_pkg::*;
	localparam int MSC = 20;
	typedef struct {logic [7:0] a; logic [31:0] w; logic [31:0] e;} pmi_row_t;
	logic hclk = 0, hresetn = 0, hsel = 0, hwrite = 0, obj = 1;
	logic [31:0] haddr = 0, hwdata = 0, hrdata, pos_now, d, t1, push_target, jog_speed_pps;
	logic [1:0] htrans = 0;
	logic [2:0] hsize = 3'h2;
	logic [3:0] in_pins = 0;
	logic [7:0] torque_cap_pct;
	logic [6:0] inch_dist;
	logic hreadyout, hresp, torque_reached, target_reached, cap_cw, cap_ccw, move_run, decel_stop;
	logic inch_start, jog_run, jog_dir_cw, servo_enable, alarm_clear, report_req;
	int fail_count = 0, tests_run = 0, inch_n = 0, stop_n = 0, clr_n = 0, rep_n = 0;
	pmi_row_t rows[7] = '{'{PMI_REG_PUSH_CFG, 32'h0BB8_2803, 32'h0BB8_2803},
		'{PMI_REG_TARGET, 32'hFFFF_FC18, 32'hFFFF_FC18}, '{PMI_REG_JOG_CFG, 32'h0064_0032, 32'h0064_0032},
		'{PMI_REG_MISC_CFG, 32'h0100_0002, 32'h0100_0002}, '{PMI_REG_INPUT_CFG, 32'h0005_0000, 32'h0005_0000},
		'{PMI_REG_CTRL, 32'h0000_0000, 32'h0000_0000}, '{8'h20, 32'hDEAD_BEEF, 32'h0000_0000}};
	pmi_push_inputs #(.MS_CYCLES(MSC)) DUT (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata),
		.hreadyout(hreadyout), .hresp(hresp), .in_pins(in_pins), .pos_now(pos_now),
		.torque_reached(torque_reached), .target_reached(target_reached), .push_target(push_target),
		.torque_cap_pct(torque_cap_pct), .cap_cw(cap_cw), .cap_ccw(cap_ccw), .move_run(move_run),
		.decel_stop(decel_stop), .inch_start(inch_start), .inch_dist(inch_dist), .jog_run(jog_run),
		.jog_dir_cw(jog_dir_cw), .jog_speed_pps(jog_speed_pps), .servo_enable(servo_enable),
		.alarm_clear(alarm_clear), .report_req(report_req));
	pmi_motor_model MODEL (.hclk(hclk), .hresetn(hresetn), .move_run(move_run), .obj(obj), .pos_now(pos_now),
		.torque_reached(torque_reached), .target_reached(target_reached));
	// Clock, 50 ns period
	initial begin
		forever #25 hclk = ~hclk;
	end
	// Pulse counters
	always @(posedge hclk) begin
		if (decel_stop === 1'b1) stop_n++;
		if (inch_start === 1'b1) inch_n++;
		if (alarm_clear === 1'b1) clr_n++;
		if (report_req === 1'b1) rep_n++;
	end
	// One single AHB-Lite transfer
	task ahb(input logic w, input logic [7:0] a, input logic [31:0] wd, output logic [31:0] rd);
		@(posedge hclk);
		hsel <= 1'b1;
		haddr <= {24'h00_0000, a};
		hwrite <= w;
		htrans <= 2'h2;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'h0;
		hsel <= 1'b0;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask : ahb
	task wr(input logic [7:0] a, input logic [31:0] wd);
		logic [31:0] x;
		ahb(1'b1, a, wd, x);
	endtask : wr
	task tick(input int n);
		repeat (n) @(posedge hclk);
		#1;
	endtask : tick
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			fail_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task conclude;
		$display("checks %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : conclude
	// Watchdog
	initial begin
		#(50 * 20000);
		fail_count++;
		conclude();
	end
	// Main sequence
	initial begin
		repeat (20) @(posedge hclk);
		hresetn <= 1'b1;
		ahb(0, PMI_REG_PUSH_CFG, 0, d); chk("push_cfg", d, PMI_PUSH_CFG_RST);
		ahb(0, PMI_REG_INPUT_CFG, 0, d); chk("input_cfg", d, PMI_INPUT_CFG_RST);
		ahb(0, PMI_REG_JOG_CFG, 0, d); chk("jog_cfg", d, PMI_JOG_CFG_RST);
		ahb(0, PMI_REG_STATUS, 0, d); chk("status", d[15:0], 16);
		$display("reset test done");
		foreach (rows[i]) begin
			wr(rows[i].a, rows[i].w);
			ahb(0, rows[i].a, 0, d); chk("row", d, rows[i].e);
		end
		$display("register table done");
		wr(PMI_REG_PUSH_CFG, 32'h0003_2801); wr(PMI_REG_TARGET, 32'h0000_03E8); wr(PMI_REG_CTRL, 32'h1);
		tick(2);
		chk("move", move_run, 1); chk("cw", cap_cw, 1); chk("ccw", cap_ccw, 0);
		chk("pct", torque_cap_pct, 40); chk("target", push_target, 32'h3E8);
		tick(8); ahb(0, PMI_REG_STATUS, 0, d); chk("pushing", d[15:0], 32);
		tick(5 * MSC); ahb(0, PMI_REG_STATUS, 0, d); chk("done", d[15:0], 40);
		ahb(0, PMI_REG_PUSH_TIME, 0, d); chk("time", d, 3);
		$display("timed push done");
		wr(PMI_REG_PUSH_CFG, 32'h0064_3203); wr(PMI_REG_TARGET, 32'h0000_0100); wr(PMI_REG_CTRL, 32'h2);
		tick(10); chk("rel", push_target, 32'h110); chk("both", cap_ccw & cap_cw, 1);
		tick(3 * MSC); wr(PMI_REG_CTRL, 32'h4); tick(2); chk("paused", move_run, 0);
		ahb(0, PMI_REG_PUSH_TIME, 0, t1); tick(3 * MSC); ahb(0, PMI_REG_PUSH_TIME, 0, d);
		chk("frozen", d, t1);
		wr(PMI_REG_CTRL, 32'h8); tick(2); chk("resume", move_run, 1);
		wr(PMI_REG_CTRL, 32'h4); wr(PMI_REG_CTRL, 32'h4); tick(2);
		chk("uncap", {move_run, cap_cw, cap_ccw}, 0);
		$display("pause test done");
		wr(PMI_REG_PUSH_CFG, 32'h0001_2800); wr(PMI_REG_TARGET, 32'h0000_03E8); wr(PMI_REG_CTRL, 32'h1);
		tick(5 * MSC); chk("cont", move_run, 1);
		wr(PMI_REG_CTRL, 32'h10); tick(2); chk("stopped", move_run, 0);
		obj <= 1'b0; wr(PMI_REG_CTRL, 32'h1); tick(10);
		ahb(0, PMI_REG_STATUS, 0, d); chk("miss", d[16:0], 32'h1_0128);
		wr(PMI_REG_CTRL, 32'h20); ahb(0, PMI_REG_STATUS, 0, d); chk("clr", d[23:16], 0);
		obj <= 1'b1;
		$display("continuous and miss done");
		wr(PMI_REG_INPUT_CFG, 32'h0005_0050);
		@(posedge hclk); in_pins[1] <= 1'b1; tick(2 * MSC);
		@(posedge hclk); in_pins[1] <= 1'b0; tick(8 * MSC); chk("glitch", servo_enable, 0);
		@(posedge hclk); in_pins[1] <= 1'b1; tick(8 * MSC);
		chk("servo", servo_enable, 1); chk("alarm", clr_n, 1);
		chk("report", rep_n, 3);
		ahb(0, PMI_REG_STATUS, 0, d); chk("st_on", d[15:0], 8);
		@(posedge hclk); in_pins[1] <= 1'b0; tick(8 * MSC);
		ahb(0, PMI_REG_STATUS, 0, d); chk("st_off", {servo_enable, d[15:0]}, 16);
		wr(PMI_REG_INPUT_CFG, 32'h0001_0002);
		@(posedge hclk); in_pins[0] <= 1'b1; tick(4 * MSC); chk("decel", stop_n, 1);
		ahb(0, PMI_REG_STATUS, 0, d); chk("lim", {d[18], d[15:0]}, 32'h1_0100);
		wr(PMI_REG_TARGET, 32'h0); wr(PMI_REG_CTRL, 32'h1); tick(3); chk("toward", move_run, 0);
		wr(PMI_REG_TARGET, 32'h3E8); wr(PMI_REG_CTRL, 32'h1); tick(3); chk("away", move_run, 1);
		wr(PMI_REG_CTRL, 32'h10);
		@(posedge hclk); in_pins[0] <= 1'b0;
		$display("servo and limit done");
		wr(PMI_REG_INPUT_CFG, 32'h0001_0200);
		@(posedge hclk); in_pins[2] <= 1'b1; tick(3 * MSC); chk("lim3", stop_n, 1);
		@(posedge hclk); in_pins[2] <= 1'b0;
		$display("function limits done");
		wr(PMI_REG_INPUT_CFG, 32'h0001_7640);
		@(posedge hclk); in_pins[1] <= 1'b1; tick(4 * MSC);
		wr(PMI_REG_CTRL, 32'h1); tick(3); chk("manual", move_run, 0);
		@(posedge hclk); in_pins[2] <= 1'b1; tick(3 * MSC);
		chk("inch", {inch_n[1:0], jog_dir_cw, inch_dist}, {2'h1, 1'b0, 7'd100});
		chk("speed", jog_speed_pps, 32'h0000_1388);
		tick(3 * MSC); chk("jog", jog_run, 1);
		@(posedge hclk); in_pins[2] <= 1'b0; tick(4 * MSC); chk("jog_off", jog_run, 0);
		wr(PMI_REG_MISC_CFG, 32'h0100_0000);
		@(posedge hclk); in_pins[3] <= 1'b1; tick(3 * MSC);
		chk("jog_now", {jog_run, jog_dir_cw}, 2'h3);
		@(posedge hclk); in_pins[3] <= 1'b0;
		$display("manual jog done");
		@(posedge hclk); hresetn <= 1'b0; tick(2);
		chk("rst_out", {servo_enable, jog_run, move_run, decel_stop, inch_start, report_req}, 0);
		@(posedge hclk); hresetn <= 1'b1;
		ahb(0, PMI_REG_STATUS, 0, d); chk("rst_status", d[15:0], 16);
		ahb(0, PMI_REG_MISC_CFG, 0, d); chk("rst_misc", d, PMI_MISC_CFG_RST);
		chk("bus", {hreadyout, hresp}, 2);
		$display("mid-run reset done");
		conclude();
	end
endmodule : pmi_push_inputs_tb
